// ---- trip_pkg.sv ----
// Package with register map, fault codes and timing constants for the trip recorder.
package trip_pkg;
    localparam int CLOCK_HZ = 20_000_000;
    localparam int SAVE_SETTLE_MS = 6000;
    localparam int SAVE_SETTLE_CYCLES = SAVE_SETTLE_MS * (CLOCK_HZ / 1000);

    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_INIT_SEL = 12'h004;
    localparam logic [11:0] REG_LOCK_MODE = 12'h008;
    localparam logic [11:0] REG_MAX_FREQ = 12'h00C;
    localparam logic [11:0] REG_UPPER_LIMIT = 12'h010;
    localparam logic [11:0] REG_FREQ_CMD = 12'h014;
    localparam logic [11:0] REG_EDIT = 12'h018;
    localparam logic [11:0] REG_STORE = 12'h01C;
    localparam logic [11:0] REG_STATUS = 12'h020;
    localparam logic [11:0] REG_NEWEST = 12'h024;
    localparam logic [11:0] REG_MIDDLE = 12'h028;
    localparam logic [11:0] REG_OLDEST = 12'h02C;
    localparam logic [11:0] REG_FREQ_OUT = 12'h030;

    localparam int CTRL_INIT_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int EDIT_INDEX_LSB = 16;
    localparam int EDIT_INDEX_MSB = 18;
    localparam int STAT_TRIPPED = 0;
    localparam int STAT_PENDING = 1;
    localparam int STAT_DIRTY = 2;
    localparam int STAT_SETTLED = 3;
    localparam int STAT_REJECT = 4;
    localparam int STAT_LOST = 5;
    localparam int STAT_NV_DUE = 6;
    localparam int STAT_PHASE_LSB = 8;
    localparam int STAT_CODE_LSB = 16;

    localparam logic [2:0] PARAM_MAX_FREQ = 3'h0;
    localparam logic [2:0] PARAM_UPPER_LIMIT = 3'h1;
    localparam logic [2:0] PARAM_FREQ_CMD = 3'h2;
    localparam logic [2:0] PARAM_LOCK_MODE = 3'h3;
    localparam logic [2:0] PARAM_INIT_SEL = 3'h4;
    localparam logic [4:0] RUN_LOCK_MASK = 5'h1B;

    localparam logic [15:0] MAX_FREQ_RESET = 16'h0258;
    localparam logic [15:0] UPPER_LIMIT_RESET = 16'h0258;
    localparam logic [15:0] FREQ_CMD_RESET = 16'h0000;
    localparam logic [7:0] LOCK_MODE_RESET = 8'h00;
    localparam logic [7:0] LOCK_ALL = 8'h00;
    localparam logic [7:0] INIT_SEL_RESET = 8'h00;
    localparam logic [7:0] INIT_CLEAR_HISTORY = 8'h00;
    localparam logic [7:0] OVERLOAD_LEVEL = 8'hC0;

    localparam logic [7:0] CODE_EMPTY = 8'h00;
    localparam logic [7:0] CODE_OC_CONST = 8'h01;
    localparam logic [7:0] CODE_OC_DECEL = 8'h02;
    localparam logic [7:0] CODE_OC_ACCEL = 8'h03;
    localparam logic [7:0] CODE_OC_OTHER = 8'h04;
    localparam logic [7:0] CODE_OVERLOAD = 8'h05;
    localparam logic [7:0] CODE_OVERVOLT = 8'h07;
    localparam logic [7:0] CODE_NVMEM = 8'h08;
    localparam logic [7:0] CODE_UNDERVOLT = 8'h09;
    localparam logic [7:0] CODE_CPU = 8'h0B;
    localparam logic [7:0] CODE_OUTSIDE = 8'h0C;

    typedef enum logic [1:0] {PHASE_CONST, PHASE_DECEL, PHASE_ACCEL, PHASE_OTHER} phase_e;
    typedef enum logic {ST_READY, ST_TRIPPED} trip_e;
endpackage : trip_pkg

// ---- input_sync.sv ----
// Two flip-flop synchroniser for a group of independent pin levels.
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // Each bit is a separate level, so skew between bits is harmless.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : input_sync

// ---- drive_fault_trip_recorder.sv ----
// Fault trip, trip history and parameter edit logic of the motor drive, with APB registers.
`timescale 1ns/1ps
module drive_fault_trip_recorder
    import trip_pkg::*;
#(
    parameter int SAVE_CYCLES = SAVE_SETTLE_CYCLES
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic OVERCURRENT_I,
    input wire logic THERMAL_I,
    input wire logic OVERVOLT_I,
    input wire logic NVMEM_FAULT_I,
    input wire logic UNDERVOLT_I,
    input wire logic CPU_FAULT_I,
    input wire logic OUTSIDE_TRIP_I,
    input wire logic FAULT_CLEAR_I,
    input wire logic EDIT_LOCK_I,
    input wire logic RUN_I,
    input wire logic STOP_RESET_KEY_I,
    input wire logic POWER_GOOD_I,
    input wire logic [7:0] LOAD_CURRENT_I,
    output logic MOTOR_ENABLE_O,
    output logic [7:0] DISPLAY_CODE_O,
    output logic [15:0] FREQ_OUT_O,
    output logic NV_WRITE_O
);
    logic [11:0] pins;
    logic oc, thermal, ov, nvmem, uv, cpu, outside;
    logic fault_clear_input, edit_lock_input, run, stop_key, pg;
    logic stop_key_d, pg_d, clear_edge, pg_fall;
    trip_e state;
    phase_e phase;
    logic [7:0] fault_code;
    logic fault_any, trip_event, nv_due, nv_pending;
    logic [31:0] newest_fault_slot, middle_fault_slot, oldest_fault_slot;
    logic [15:0] max_frequency_setting, frequency_upper_limit, freq_cmd;
    logic [7:0] lock_mode_select, init_function_select;
    logic [15:0] limit, target;
    logic overload;
    logic [2:0] pend_index;
    logic [15:0] pend_value;
    logic pend_valid, commit_try, reject, commit;
    logic run_lock_hit, soft_lock_hit;
    logic [31:0] settle_cnt;
    logic settled, save_dirty, save_lost, edit_reject;
    logic setup, wr, mapped, init_clear, flag_clear;
    logic [31:0] read_mux;

    input_sync #(.WIDTH(12)) u_sync (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .d_i({POWER_GOOD_I, STOP_RESET_KEY_I, RUN_I, EDIT_LOCK_I, FAULT_CLEAR_I,
              OUTSIDE_TRIP_I, CPU_FAULT_I, UNDERVOLT_I, NVMEM_FAULT_I, OVERVOLT_I,
              THERMAL_I, OVERCURRENT_I}),
        .q_o(pins)
    );
    assign {pg, stop_key, run, edit_lock_input, fault_clear_input,
            outside, cpu, uv, nvmem, ov, thermal, oc} = pins;

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            stop_key_d <= 1'b0;
            pg_d <= 1'b0;
        end
        else
        begin
            stop_key_d <= stop_key;
            pg_d <= pg;
        end
    end
    assign clear_edge = stop_key && !stop_key_d;
    assign pg_fall = pg_d && !pg;

    // APB decode; the slave never waits, so every access completes in two cycles.
    assign setup = PSEL_I && !PENABLE_I;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign init_clear = wr && PADDR_I == REG_CTRL && PWDATA_I[CTRL_INIT_BIT]
                        && init_function_select == INIT_CLEAR_HISTORY;
    assign flag_clear = wr && PADDR_I == REG_CTRL && PWDATA_I[CTRL_CLEAR_BIT];

    always_comb
    begin
        mapped = 1'b1;
        read_mux = 32'h0000_0000;
        case (PADDR_I)
            REG_CTRL, REG_STORE: read_mux = 32'h0000_0000;
            REG_INIT_SEL: read_mux = {24'h000000, init_function_select};
            REG_LOCK_MODE: read_mux = {24'h000000, lock_mode_select};
            REG_MAX_FREQ: read_mux = {16'h0000, max_frequency_setting};
            REG_UPPER_LIMIT: read_mux = {16'h0000, frequency_upper_limit};
            REG_FREQ_CMD: read_mux = {16'h0000, freq_cmd};
            REG_EDIT: read_mux = {13'h0000, pend_index, pend_value};
            REG_STATUS:
            begin
                read_mux[STAT_TRIPPED] = state == ST_TRIPPED;
                read_mux[STAT_PENDING] = pend_valid;
                read_mux[STAT_DIRTY] = save_dirty;
                read_mux[STAT_SETTLED] = settled;
                read_mux[STAT_REJECT] = edit_reject;
                read_mux[STAT_LOST] = save_lost;
                read_mux[STAT_NV_DUE] = nv_pending;
                read_mux[STAT_PHASE_LSB +: 2] = phase;
                read_mux[STAT_CODE_LSB +: 8] = DISPLAY_CODE_O;
            end
            REG_NEWEST: read_mux = newest_fault_slot;
            REG_MIDDLE: read_mux = middle_fault_slot;
            REG_OLDEST: read_mux = oldest_fault_slot;
            REG_FREQ_OUT: read_mux = {16'h0000, FREQ_OUT_O};
            default: mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so it stands through the access phase.
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            PRDATA_O <= 32'h0000_0000;
        else if (setup && !PWRITE_I)
            PRDATA_O <= read_mux;
    end

    // Fault classification with fixed priority; processor faults come first.
    assign nv_due = nv_pending && pg;
    assign fault_any = oc || thermal || ov || nvmem || uv || cpu || outside || nv_due;
    assign trip_event = state == ST_READY && fault_any;
    always_comb
    begin
        fault_code = CODE_EMPTY;
        if (cpu)
            fault_code = CODE_CPU;
        else if (nvmem || nv_due)
            fault_code = CODE_NVMEM;
        else if (uv)
            fault_code = CODE_UNDERVOLT;
        else if (ov)
            fault_code = CODE_OVERVOLT;
        else if (oc)
        begin
            case (phase)
                PHASE_CONST: fault_code = CODE_OC_CONST;
                PHASE_DECEL: fault_code = CODE_OC_DECEL;
                PHASE_ACCEL: fault_code = CODE_OC_ACCEL;
                default: fault_code = CODE_OC_OTHER;
            endcase
        end
        else if (thermal)
            fault_code = CODE_OVERLOAD;
        else if (outside)
            fault_code = CODE_OUTSIDE;
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            state <= ST_READY;
        else
        begin
            case (state)
                ST_READY: if (trip_event) state <= ST_TRIPPED;
                ST_TRIPPED: if (clear_edge) state <= ST_READY;
                default: state <= ST_READY;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            MOTOR_ENABLE_O <= 1'b0;
            DISPLAY_CODE_O <= CODE_EMPTY;
        end
        else
        begin
            MOTOR_ENABLE_O <= run && pg && state == ST_READY && !trip_event;
            if (trip_event)
                DISPLAY_CODE_O <= fault_code;
            else if (state == ST_TRIPPED && clear_edge)
                DISPLAY_CODE_O <= CODE_EMPTY;
        end
    end

    // A power loss while the fault clear input is high is remembered until power is good again, then it trips.
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            nv_pending <= 1'b0;
        else if (pg_fall && fault_clear_input)
            nv_pending <= 1'b1;
        else if (trip_event && fault_code == CODE_NVMEM)
            nv_pending <= 1'b0;
    end

    // A trip in the same cycle as an erase wins, so the new fault is never lost.
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            newest_fault_slot <= {24'h000000, CODE_EMPTY};
            middle_fault_slot <= {24'h000000, CODE_EMPTY};
            oldest_fault_slot <= {24'h000000, CODE_EMPTY};
        end
        else if (trip_event)
        begin
            newest_fault_slot <= {FREQ_OUT_O, LOAD_CURRENT_I, fault_code};
            middle_fault_slot <= newest_fault_slot;
            oldest_fault_slot <= middle_fault_slot;
        end
        else if (init_clear)
        begin
            newest_fault_slot <= {24'h000000, CODE_EMPTY};
            middle_fault_slot <= {24'h000000, CODE_EMPTY};
            oldest_fault_slot <= {24'h000000, CODE_EMPTY};
        end
    end

    // Output frequency ramps one step a cycle toward a clamped target, but drops straight to the limit when above it.
    assign limit = max_frequency_setting < frequency_upper_limit ?
                   max_frequency_setting : frequency_upper_limit;
    assign target = (run && pg && state == ST_READY) ?
                    (freq_cmd < limit ? freq_cmd : limit) : 16'h0000;
    assign overload = LOAD_CURRENT_I >= OVERLOAD_LEVEL;
    always_comb
    begin
        if (overload && FREQ_OUT_O != 16'h0000)
            phase = PHASE_DECEL;
        else if (FREQ_OUT_O < target)
            phase = PHASE_ACCEL;
        else if (FREQ_OUT_O > target)
            phase = PHASE_DECEL;
        else if (FREQ_OUT_O != 16'h0000)
            phase = PHASE_CONST;
        else
            phase = PHASE_OTHER;
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            FREQ_OUT_O <= 16'h0000;
        else if (FREQ_OUT_O > limit)
            FREQ_OUT_O <= limit;
        else if (overload && FREQ_OUT_O != 16'h0000)
            FREQ_OUT_O <= FREQ_OUT_O - 16'h0001;
        else if (FREQ_OUT_O < target)
            FREQ_OUT_O <= FREQ_OUT_O + 16'h0001;
        else if (FREQ_OUT_O > target)
            FREQ_OUT_O <= FREQ_OUT_O - 16'h0001;
    end

    // Edits wait in a pending slot; only the store register moves them into effect.
    assign commit_try = wr && PADDR_I == REG_STORE && pend_valid;
    assign run_lock_hit = run && RUN_LOCK_MASK[pend_index];
    assign soft_lock_hit = edit_lock_input
                           && (lock_mode_select == LOCK_ALL || pend_index != PARAM_FREQ_CMD);
    assign reject = run_lock_hit || soft_lock_hit;
    assign commit = commit_try && !reject && !pg_fall;

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            pend_index <= 3'h0;
            pend_value <= 16'h0000;
            pend_valid <= 1'b0;
        end
        else if (pg_fall || commit_try)
            pend_valid <= 1'b0;
        else if (wr && PADDR_I == REG_EDIT)
        begin
            pend_index <= PWDATA_I[EDIT_INDEX_MSB:EDIT_INDEX_LSB];
            pend_value <= PWDATA_I[15:0];
            pend_valid <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            max_frequency_setting <= MAX_FREQ_RESET;
            frequency_upper_limit <= UPPER_LIMIT_RESET;
            freq_cmd <= FREQ_CMD_RESET;
            lock_mode_select <= LOCK_MODE_RESET;
            init_function_select <= INIT_SEL_RESET;
        end
        else if (commit)
        begin
            case (pend_index)
                PARAM_MAX_FREQ: max_frequency_setting <= pend_value;
                PARAM_UPPER_LIMIT: frequency_upper_limit <= pend_value;
                PARAM_FREQ_CMD: freq_cmd <= pend_value;
                PARAM_LOCK_MODE: lock_mode_select <= pend_value[7:0];
                PARAM_INIT_SEL: init_function_select <= pend_value[7:0];
                default: freq_cmd <= freq_cmd;
            endcase
        end
    end

    // The save only counts as safe once the full settle time has passed since the last commit.
    assign settled = settle_cnt >= 32'(SAVE_CYCLES);
    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            settle_cnt <= 32'h0000_0000;
        else if (commit)
            settle_cnt <= 32'h0000_0000;
        else if (!settled)
            settle_cnt <= settle_cnt + 32'h0000_0001;
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            save_dirty <= 1'b0;
            save_lost <= 1'b0;
            NV_WRITE_O <= 1'b0;
        end
        else
        begin
            NV_WRITE_O <= pg_fall && save_dirty && settled;
            if (pg_fall)
                save_dirty <= 1'b0;
            else if (commit)
                save_dirty <= 1'b1;
            if (pg_fall && save_dirty && !settled)
                save_lost <= 1'b1;
            else if (flag_clear)
                save_lost <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I)
    begin
        if (RESET_I)
            edit_reject <= 1'b0;
        else if (commit_try && reject)
            edit_reject <= 1'b1;
        else if (flag_clear)
            edit_reject <= 1'b0;
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    sequence s_trip;
        trip_event;
    endsequence
    sequence s_locked_store;
        commit_try && run && RUN_LOCK_MASK[pend_index];
    endsequence

    a_trip_output_off: assert property (s_trip |=> !MOTOR_ENABLE_O && state == ST_TRIPPED)
        else $error("Trip did not switch the motor output off.");
    a_stop_mode_trip: assert property (!run && cpu && state == ST_READY |=> state == ST_TRIPPED)
        else $error("Internal fault did not trip in stop mode.");
    a_clear_key_exit: assert property (state == ST_TRIPPED && clear_edge |=> state == ST_READY)
        else $error("Stop key did not clear the trip.");
    a_init_erase: assert property (init_clear && !trip_event |=> newest_fault_slot[7:0] == CODE_EMPTY
                                   && oldest_fault_slot[7:0] == CODE_EMPTY && $stable(freq_cmd))
        else $error("Initialization did not erase only the history.");
    a_display_code: assert property (s_trip |=> DISPLAY_CODE_O == $past(fault_code))
        else $error("Display does not show the trip code.");
    a_oc_accel_code: assert property (s_trip ##0 (oc && !cpu && !nvmem && !nv_due && !uv && !ov
                                      && phase == PHASE_ACCEL) |=> DISPLAY_CODE_O == 8'h03)
        else $error("Over-current during acceleration coded wrongly.");
    a_history_shift: assert property (s_trip |=> middle_fault_slot == $past(newest_fault_slot)
                                      && oldest_fault_slot == $past(middle_fault_slot))
        else $error("History did not shift on a trip.");
    a_trip_snapshot: assert property (s_trip |=> newest_fault_slot[15:8] == $past(LOAD_CURRENT_I))
        else $error("Operating data not latched with the fault.");
    a_nv_report: assert property (pg_fall && fault_clear_input |=> nv_pending)
        else $error("Power loss under fault clear not remembered.");
    a_edit_lost: assert property (pg_fall |=> !pend_valid && !save_dirty)
        else $error("Uncommitted edit survived power loss.");
    a_run_lock: assert property (s_locked_store |=> $stable(max_frequency_setting)
                                 && $stable(lock_mode_select) && edit_reject)
        else $error("Run-locked parameter changed in run mode.");
    a_soft_lock: assert property (commit_try && edit_lock_input && lock_mode_select == LOCK_ALL
                                  |=> $stable(freq_cmd))
        else $error("Edit lock did not block the edit.");
    a_freq_clamp: assert property (1'b1 |=> FREQ_OUT_O <= $past(limit) || $past(FREQ_OUT_O > limit))
        else $error("Output frequency above the limit.");
    a_overload_cut: assert property (overload && FREQ_OUT_O != 16'h0000 |=> FREQ_OUT_O < $past(FREQ_OUT_O))
        else $error("Overload restriction did not reduce output.");
    a_early_save: assert property (pg_fall && !settled |=> !NV_WRITE_O)
        else $error("Save issued before the settle time.");
endmodule : drive_fault_trip_recorder

// ---- stage_model.sv ----
// Behavioural model of the power stage sensors, the supply and the operator keypad.
`timescale 1ns/1ps
module stage_model (
    input wire logic clk_i,
    input wire logic [6:0] fault_req_i,
    input wire logic press_i,
    input wire logic power_i,
    output logic [6:0] sensor_o,
    output logic stop_key_o,
    output logic power_good_o
);
    int hold = 0;
    initial sensor_o = '0;
    initial stop_key_o = 1'b0;
    // Supply follows the bench, which only drops it once the save window has run.
    assign power_good_o = power_i;
    // Sensor levels follow the stage, whether the motor runs or not.
    always @(posedge clk_i) sensor_o <= fault_req_i;
    // A press is held a few cycles, as a finger would, so the sync sees one clean edge.
    always @(posedge clk_i)
    begin
        if (press_i) hold <= 4;
        else if (hold > 0) hold <= hold - 1;
        stop_key_o <= press_i || hold > 1;
    end
endmodule : stage_model

// ---- tb_drive_fault_trip_recorder.sv ----
// Self-checking testbench for the fault trip recorder.
`timescale 1ns/1ps
module tb_drive_fault_trip_recorder;
    import trip_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, run = 0, lock = 0, press = 0;
    logic pwr_on = 1, clr = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, slverr, motor_en, stop_key, pgood, nvw;
    logic [6:0] fault_req = 0, sensor;
    logic [7:0] code, load = 0;
    logic [15:0] fout;
    logic [7:0] codes [7] = '{CODE_OC_OTHER, CODE_OVERLOAD, CODE_OVERVOLT, CODE_NVMEM,
        CODE_UNDERVOLT, CODE_CPU, CODE_OUTSIDE};
    int err_count = 0, n_compared = 0, cycles = 0, n_nvw = 0;
    initial forever #25 clk = ~clk;
    stage_model i_stage_model (.clk_i(clk), .fault_req_i(fault_req), .press_i(press),
        .power_i(pwr_on), .sensor_o(sensor), .stop_key_o(stop_key), .power_good_o(pgood));
    drive_fault_trip_recorder #(.SAVE_CYCLES(20)) i_drive_fault_trip_recorder (
        .CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .OVERCURRENT_I(sensor[0]), .THERMAL_I(sensor[1]),
        .OVERVOLT_I(sensor[2]), .NVMEM_FAULT_I(sensor[3]), .UNDERVOLT_I(sensor[4]),
        .CPU_FAULT_I(sensor[5]), .OUTSIDE_TRIP_I(sensor[6]), .FAULT_CLEAR_I(clr),
        .EDIT_LOCK_I(lock), .RUN_I(run), .STOP_RESET_KEY_I(stop_key), .POWER_GOOD_I(pgood),
        .LOAD_CURRENT_I(load), .MOTOR_ENABLE_O(motor_en), .DISPLAY_CODE_O(code),
        .FREQ_OUT_O(fout), .NV_WRITE_O(nvw));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask : chk
    task automatic rdchk(input string n, input logic [11:0] a, input logic [15:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, {16'h0, e}, {16'h0, rd[15:0]});
    endtask : rdchk
    task automatic edit(input logic [2:0] idx, input logic [15:0] v);
        apb(1'b1, REG_EDIT, {13'h0, idx, v});
        apb(1'b1, REG_STORE, 32'h0);
    endtask : edit
    task automatic t_empty;
        rdchk("newest", REG_NEWEST, {8'h0, CODE_EMPTY});
        rdchk("oldest", REG_OLDEST, {8'h0, CODE_EMPTY});
        apb(1'b0, 12'hFFC, 32'h0);
        chk("slverr", 32'h1, {31'h0, slverr});
        $display("test empty done");
    endtask : t_empty
    task automatic t_faults;
        for (int i = 0; i < 7; i++)
        begin
            run <= (i != 5);
            cyc(4);
            chk("motor on", {31'h0, i != 5}, {31'h0, motor_en});
            fault_req <= 7'h01 << i;
            cyc(6);
            chk("display", {24'h0, codes[i]}, {24'h0, code});
            chk("motor", 32'h0, {31'h0, motor_en});
            fault_req <= 7'h00;
            press <= 1'b1;
            cyc(1);
            press <= 1'b0;
            cyc(10);
            chk("cleared", 32'h0, {24'h0, code});
        end
        $display("test faults done");
    endtask : t_faults
    task automatic t_history;
        rdchk("newest", REG_NEWEST, {8'h0, CODE_OUTSIDE});
        rdchk("middle", REG_MIDDLE, {8'h0, CODE_CPU});
        rdchk("oldest", REG_OLDEST, {8'h0, CODE_UNDERVOLT});
        apb(1'b1, REG_CTRL, 32'h1);
        rdchk("erased", REG_MIDDLE, {8'h0, CODE_EMPTY});
        rdchk("kept", REG_MAX_FREQ, MAX_FREQ_RESET);
        $display("test history done");
    endtask : t_history
    task automatic t_edit;
        run <= 1'b0;
        cyc(4);
        apb(1'b1, REG_EDIT, {13'h0, PARAM_FREQ_CMD, 16'h0100});
        rdchk("pending", REG_FREQ_CMD, FREQ_CMD_RESET);
        apb(1'b1, REG_STORE, 32'h0);
        rdchk("stored", REG_FREQ_CMD, 16'h0100);
        run <= 1'b1;
        cyc(4);
        edit(PARAM_MAX_FREQ, 16'h0100);
        rdchk("runlock", REG_MAX_FREQ, MAX_FREQ_RESET);
        run <= 1'b0;
        lock <= 1'b1;
        cyc(4);
        edit(PARAM_FREQ_CMD, 16'h0050);
        rdchk("swlock", REG_FREQ_CMD, 16'h0100);
        lock <= 1'b0;
        $display("test edit done");
    endtask : t_edit
    task automatic t_motion;
        load <= 8'h40;
        cyc(4);
        edit(PARAM_UPPER_LIMIT, 16'h0040);
        run <= 1'b1;
        cyc(20);
        fault_req <= 7'h01;
        cyc(6);
        chk("accel oc", {24'h0, CODE_OC_ACCEL}, {24'h0, code});
        rdchk("snapshot", REG_NEWEST, {8'h40, CODE_OC_ACCEL});
        fault_req <= 7'h00;
        press <= 1'b1;
        cyc(1);
        press <= 1'b0;
        cyc(100);
        chk("clamp", 32'h0040, {16'h0, fout});
        load <= 8'hC0;
        cyc(10);
        chk("overload", 32'h1, {31'h0, fout < 16'h0040});
        load <= 8'h00;
        $display("test motion done");
    endtask : t_motion
    task automatic t_power;
        run <= 1'b0;
        cyc(4);
        edit(PARAM_FREQ_CMD, 16'h0020);
        cyc(30);
        apb(1'b1, REG_EDIT, {13'h0, PARAM_FREQ_CMD, 16'h0077});
        clr <= 1'b1;
        pwr_on <= 1'b0;
        cyc(6);
        chk("nv write", 32'h1, n_nvw);
        pwr_on <= 1'b1;
        clr <= 1'b0;
        cyc(6);
        chk("nv report", {24'h0, CODE_NVMEM}, {24'h0, code});
        apb(1'b1, REG_STORE, 32'h0);
        rdchk("unstored", REG_FREQ_CMD, 16'h0020);
        $display("test power done");
    endtask : t_power
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Each memory write pulse lasts one cycle, so it is counted here rather than polled.
    always @(posedge clk)
        if (nvw === 1'b1) n_nvw++;
    // The ceiling is more than forty times the length of all tests together.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            summarize();
        end
    end
    initial
    begin
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        t_empty();
        t_faults();
        t_history();
        t_edit();
        t_motion();
        t_power();
        summarize();
    end
endmodule : tb_drive_fault_trip_recorder
